// file: edge_src.sv
`timescale 1ns/1ps
module edge_src #(
  parameter HOLD = 16
) (
  // clock
  input wire clk_sys,
  // pulse requests
  input wire go_a,
  input wire go_b,
  // driven pins
  output reg edge_in_a,
  output reg edge_in_b
);
  integer cnt_a;
  integer cnt_b;
  // ****************
  // pulse shaping
  // ****************
  initial begin
    {cnt_a, cnt_b} = 0;
    {edge_in_a, edge_in_b} = 2'b00;
  end
  // a shorter level could be missed by the event filter
  always @(posedge clk_sys) begin
    cnt_a = go_a ? HOLD : (cnt_a > 0 ? cnt_a - 1 : 0);
    cnt_b = go_b ? HOLD : (cnt_b > 0 ? cnt_b - 1 : 0);
    edge_in_a <= cnt_a > 0;
    edge_in_b <= cnt_b > 0;
  end
endmodule

// file: periph_clk_divider.v
`timescale 1ns/1ps
`include "timer_regs.vh"

// ****************************************************************
// peripheral clock enable: sys_clock divided by 1, 2 or 4
// ****************************************************************
module periph_clk_divider (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  // divider select
  input wire [1:0] periph_clk_div,
  // one-cycle enable at the peripheral clock rate
  output reg fxp_tick
);

  reg [`PCLK_CNT_W-1:0] div_cnt_reg;
  reg hit;

  always @* begin
    case (periph_clk_div)
      `PCLK_DIV1: hit = 1'b1;
      `PCLK_DIV2: hit = (div_cnt_reg & `PCLK_MASK_DIV2) == `PCLK_MASK_DIV2;
      `PCLK_DIV4: hit = div_cnt_reg == `PCLK_MASK_DIV4;
      // prohibited code: stall rather than guess a ratio
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!resetn) begin
      div_cnt_reg <= `PCLK_CNT_ZERO;
      fxp_tick <= 1'b0;
    end else if (clk_en) begin
      div_cnt_reg <= div_cnt_reg + `PCLK_CNT_ONE;
      fxp_tick <= hit;
    end
  end

endmodule

// file: tec_chk.sv
`timescale 1ns/1ps
module tec_chk #(
  parameter CW = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  // controls
  input wire run_mode_hi,
  input wire run_mode_lo,
  input wire oneshot_trigger,
  input wire capcmp_a_select,
  input wire capcmp_b_select,
  input wire count_rd,
  input wire capcmp_a_wr,
  input wire capcmp_b_wr,
  input wire [CW-1:0] wr_data,
  input wire edge_in_a,
  // results
  input wire [CW-1:0] count_rd_data,
  input wire [CW-1:0] capcmp_a,
  input wire [CW-1:0] capcmp_b,
  input wire match_a_irq,
  input wire match_b_irq,
  input wire wave_out
);
  wire stop = !run_mode_hi && !run_mode_lo;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ****************
  // properties
  // ****************
  property p_rst;
    disable iff (1'b0) !resetn && clk_en |=> count_rd_data == 16'h0000
      && capcmp_a == 16'h0000 && capcmp_b == 16'h0000 && !wave_out;
  endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_wr_a;
    capcmp_a_wr && !capcmp_a_select && clk_en |=>
      capcmp_a == $past(wr_data);
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("write a");
  property p_hold_a;
    !capcmp_a_wr && !capcmp_a_select |=> $stable(capcmp_a);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("hold a");
  property p_irq_a;
    match_a_irq |-> !$past(capcmp_a_select);
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("irq a");
  property p_irq_b;
    match_b_irq |-> !$past(capcmp_b_select);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b");
  property p_stop;
    (stop && clk_en) [*2] |=> !match_a_irq && !match_b_irq && !wave_out;
  endproperty
  a_stop: assert property (p_stop) else $error("stop");
  // with the tick held off, back-to-back reads must return one value
  property p_rd_hold;
    (count_rd && clk_en && run_mode_lo && !oneshot_trigger) [*2] |=>
      $stable(count_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rd hold");
  property p_rd_data;
    !count_rd |=> $stable(count_rd_data);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("rd data");
  property p_rd_b;
    ($stable(edge_in_a) && !capcmp_b_wr) [*5] ##0 count_rd |=>
      $stable(capcmp_b);
  endproperty
  a_rd_b: assert property (p_rd_b) else $error("rd b");
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  reg clk_sys, resetn, clk_en, run_mode_hi, run_mode_lo, oneshot_mode;
  reg oneshot_trigger, capcmp_a_select, capcmp_a_trig_src, capcmp_b_select;
  reg edge_sel_a_hi, edge_sel_a_lo, edge_sel_b_hi, edge_sel_b_lo;
  reg wave_enable, toggle_on_a, toggle_on_b, count_rd, capcmp_a_wr;
  reg capcmp_b_wr, overflow_clr, go_a, go_b;
  reg [1:0] periph_clk_div, count_src;
  reg [15:0] wr_data, v;
  wire edge_in_a, edge_in_b, match_a_irq, match_b_irq, overflow, wave_out;
  wire [15:0] count_rd_data, capcmp_a, capcmp_b;
  integer n_mismatch, total_checks, i, d;
  timer_event_counter_16bit timer_event_counter_16bit_i (.*);
  edge_src edge_src_i (.*);
  // ****************
  // helpers
  // ****************
  task step(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      total_checks++;
      if (g !== e) begin
        n_mismatch++;
        $display("mismatch %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd(input integer n);
    begin
      count_rd = 1'b1;
      step(n);
      count_rd = 1'b0;
      step(1);
      v = count_rd_data;
    end
  endtask
  task wr(input b, input [15:0] x);
    begin
      {capcmp_b_wr, capcmp_a_wr, wr_data} = {b, !b, x};
      step(1);
      {capcmp_b_wr, capcmp_a_wr} = 2'b00;
      // let an edge pass so a following write never re-raises in one step
      step(1);
    end
  endtask
  task run(input [1:0] m);
    begin
      {run_mode_hi, run_mode_lo} = m;
      step(2);
    end
  endtask
  // bounded wait for a level on wave_out (w=1) or match_a_irq (w=0)
  task wait_lvl(input w, input l);
    begin
      i = 0;
      while (((w ? wave_out : match_a_irq) !== l) && i < 2000) begin
        step(1);
        i++;
      end
      if (i == 2000) begin
        n_mismatch++;
        stop_test;
      end
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    begin
      rd(1);
      chk("count", 16'h0000, v);
      chk("capcmp_a", 16'h0000, capcmp_a);
      chk("capcmp_b", 16'h0000, capcmp_b);
    end
  endtask
  task t_run;
    begin
      capcmp_b_select = 1'b1;
      run(2'h1);
      step(20);
      rd(2);
      d = v;
      step(20);
      rd(1);
      chk("advance", 16'h0001, v > d);
      chk("capcmp_b", 16'h0000, capcmp_b);
      run(2'h0);
      rd(1);
      chk("stopped", 16'h0000, v);
      capcmp_b_select = 1'b0;
    end
  endtask
  task t_interval;
    begin
      wr(1'b0, 16'h0004);
      {wave_enable, toggle_on_a} = 2'b11;
      for (d = 0; d < 3; d++) begin
        periph_clk_div = d[1:0];
        run(2'h3);
        wait_lvl(1'b0, 1'b1);
        step(1);
        wait_lvl(1'b0, 1'b1);
        chk("period", 16'h0005 << d, i[15:0] + 16'h0001);
        wait_lvl(1'b1, 1'b0);
        wait_lvl(1'b1, 1'b1);
        wait_lvl(1'b1, 1'b0);
        chk("half_wave", 16'h0005 << d, i[15:0]);
        run(2'h0);
      end
      {wave_enable, toggle_on_a, periph_clk_div} = 4'h0;
    end
  endtask
  task t_oneshot;
    begin
      wr(1'b1, 16'h0003);
      wr(1'b0, 16'h0008);
      {wave_enable, toggle_on_a, toggle_on_b, oneshot_mode} = 4'hf;
      run(2'h1);
      for (d = 0; d < 2; d++) begin
        step(20);
        oneshot_trigger = 1'b1;
        step(1);
        oneshot_trigger = 1'b0;
        if (d == 0) wait_lvl(1'b1, 1'b1);
        if (d == 0) wait_lvl(1'b1, 1'b0);
        if (d == 0) chk("pulse", 16'h0005, i[15:0]);
      end
      rd(1);
      chk("trig_clr", 16'h0001, v < 4);
      run(2'h0);
      {wave_enable, toggle_on_a, toggle_on_b, oneshot_mode} = 4'h0;
    end
  endtask
  task t_edge;
    begin
      // rising edge; the 1,0 code stays unused
      {edge_sel_a_hi, edge_sel_a_lo} = 2'b01;
      run(2'h2);
      step(40);
      go_a = 1'b1;
      step(1);
      go_a = 1'b0;
      step(2);
      rd(1);
      chk("edge_clr", 16'h0001, v < 8);
      run(2'h0);
      step(20);
    end
  endtask
  task t_capture;
    begin
      {capcmp_a_select, edge_sel_b_lo} = 2'b11;
      run(2'h1);
      step(30);
      go_b = 1'b1;
      step(1);
      go_b = 1'b0;
      step(3);
      rd(1);
      d = capcmp_a > 16'h0014 && capcmp_a < v;
      chk("capture", 16'h0001, d[15:0]);
      run(2'h0);
    end
  endtask
  task t_src;
    begin
      count_src = 2'h2;
      run(2'h1);
      step(160);
      rd(1);
      chk("div16", 16'h0001, v >= 9 && v <= 11);
      run(2'h0);
      {count_src, edge_sel_a_lo} = 3'b111;
      run(2'h1);
      for (d = 0; d < 3; d++) begin
        go_a = 1'b1;
        step(1);
        go_a = 1'b0;
        step(40);
      end
      rd(1);
      chk("events", 16'h0003, v);
      run(2'h0);
      count_src = 2'h0;
      chk("ovf_idle", 16'h0000, {15'h0000, overflow});
      run(2'h1);
      i = 0;
      while (overflow !== 1'b1 && i < 70000) begin
        step(1);
        i++;
      end
      chk("ovf_set", 16'h0001, {15'h0000, overflow});
      chk("ovf_time", 16'h0001, i > 65500 && i < 65540);
      overflow_clr = 1'b1;
      step(1);
      overflow_clr = 1'b0;
      step(1);
      chk("ovf_clr", 16'h0000, {15'h0000, overflow});
      run(2'h0);
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {resetn, run_mode_hi, run_mode_lo, oneshot_mode, oneshot_trigger} = 0;
    {capcmp_a_select, capcmp_a_trig_src, capcmp_b_select, go_a, go_b} = 0;
    {edge_sel_a_hi, edge_sel_a_lo, edge_sel_b_hi, edge_sel_b_lo} = 0;
    {wave_enable, toggle_on_a, toggle_on_b, count_rd, capcmp_a_wr} = 0;
    {capcmp_b_wr, overflow_clr, periph_clk_div, count_src, wr_data} = 0;
    {n_mismatch, total_checks, v} = 0;
    clk_en = 1'b1;
    step(20);
    resetn = 1'b1;
    t_reset;
    t_run;
    t_interval;
    t_oneshot;
    t_edge;
    t_capture;
    t_src;
    stop_test;
  end
endmodule
bind timer_event_counter_16bit tec_chk #(.CW(CW)) tec_chk_i (.*);

// file: timer_event_counter_16bit.v
`timescale 1ns/1ps
`include "timer_regs.vh"

// How it works
// - read-only counter counts up on count clock
// - read holds off count pulse, returns value
// - reset clears counter to zero
// - run bits both zero clears counter
// - edge-clear mode clears on edge_in_a edge
// - match-clear mode clears on capcmp_a match
// - one-shot trigger clears counter
// - counter read never captures into capcmp_b
// - capcmp_a_select picks capture or compare
// - capcmp_a whole-word writes, reset to zero
// - compare mode raises match_a_irq on equality
// - capcmp_a holds interval length minus one
// - capture on edge_in_a or edge_in_b edge
// - interval from 2 to 65536 counts
// - square wave period 2x2 to 65536x2
// - PPG output with period and width
// - one-shot pulse with chosen width
// - peripheral clock sys divided 1/2/4
// - counting starts when run bits nonzero
// - capcmp_b compare raises match_b_irq
module timer_event_counter_16bit #(
  parameter CW = 16
) (
  // clock, reset, enable
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  // clocking and mode control
  input wire [1:0] periph_clk_div,
  input wire [1:0] count_src,
  input wire run_mode_hi,
  input wire run_mode_lo,
  input wire oneshot_mode,
  input wire oneshot_trigger,
  // capture/compare control
  input wire capcmp_a_select,
  input wire capcmp_a_trig_src,
  input wire capcmp_b_select,
  input wire edge_sel_a_hi,
  input wire edge_sel_a_lo,
  input wire edge_sel_b_hi,
  input wire edge_sel_b_lo,
  // output control
  input wire wave_enable,
  input wire toggle_on_a,
  input wire toggle_on_b,
  // software access
  input wire count_rd,
  input wire capcmp_a_wr,
  input wire capcmp_b_wr,
  input wire [CW-1:0] wr_data,
  input wire overflow_clr,
  // external pins
  input wire edge_in_a,
  input wire edge_in_b,
  // results
  output reg [CW-1:0] count_rd_data,
  output reg [CW-1:0] capcmp_a,
  output reg [CW-1:0] capcmp_b,
  output reg match_a_irq,
  output reg match_b_irq,
  output reg overflow,
  output reg wave_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  reg [CW-1:0] count_reg;
  reg [CW-1:0] count_next;
  reg [`PRE_CNT_W-1:0] pre_cnt_reg;
  reg a_prev_reg;
  reg b_prev_reg;
  reg pend_reg;
  reg oneshot_act_reg;
  reg oneshot_act_next;
  reg wave_next;
  reg src_tick;
  wire fxp_tick;

  periph_clk_divider u_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .periph_clk_div(periph_clk_div),
    .fxp_tick(fxp_tick)
  );

  // ****************************************************************
  // edge detection, sampled at the peripheral clock rate
  // ****************************************************************
  // pins are seen only once per fxp period, so levels shorter than
  // that can be missed; the source must honour the minimum widths
  wire rise_a = fxp_tick & edge_in_a & ~a_prev_reg;
  wire fall_a = fxp_tick & ~edge_in_a & a_prev_reg;
  wire rise_b = fxp_tick & edge_in_b & ~b_prev_reg;
  wire fall_b = fxp_tick & ~edge_in_b & b_prev_reg;

  function valid_edge;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `ESEL_FALL: valid_edge = fall;
        `ESEL_RISE: valid_edge = rise;
        `ESEL_BOTH: valid_edge = rise | fall;
        // prohibited code: no edge is ever valid
        default: valid_edge = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] sel_a = {edge_sel_a_hi, edge_sel_a_lo};
  wire [1:0] sel_b = {edge_sel_b_hi, edge_sel_b_lo};
  wire vedge_a = valid_edge(sel_a, rise_a, fall_a);
  wire vedge_b = valid_edge(sel_b, rise_b, fall_b);
  // capcmp_a fed from edge_in_a uses the opposite edge; both -> none
  wire cap_a_from_a = (sel_a == `ESEL_RISE) ? fall_a :
                      (sel_a == `ESEL_FALL) ? rise_a : 1'b0;

  // ****************************************************************
  // run mode and count clock
  // ****************************************************************
  wire [1:0] run_mode = {run_mode_hi, run_mode_lo};
  wire running = run_mode != `TMR_RUN_STOP;
  wire edge_clr_mode = run_mode == `TMR_RUN_EDGE_CLR;
  wire match_clr_mode = run_mode == `TMR_RUN_MATCH_CLR;

  always @* begin
    case (count_src)
      `CSRC_FXP: src_tick = fxp_tick;
      `CSRC_FXP4: src_tick = fxp_tick &
        ((pre_cnt_reg & `PRE_DIV4_MASK) == `PRE_DIV4_MASK);
      `CSRC_FXP16: src_tick = fxp_tick &
        (pre_cnt_reg == `PRE_DIV16_MASK);
      `CSRC_EVENT: src_tick = vedge_a;
      default: src_tick = 1'b0;
    endcase
  end

  // a pulse that meets a read is parked until count_rd falls, not dropped
  wire tick_req = (running & src_tick) | pend_reg;
  wire cnt_tick = tick_req & ~count_rd;
  wire pend_next = tick_req & count_rd & running;

  // ****************************************************************
  // compare
  // ****************************************************************
  wire eq_a = count_reg == capcmp_a;
  wire eq_b = count_reg == capcmp_b;
  wire match_a = cnt_tick & ~capcmp_a_select & eq_a;
  wire match_b = cnt_tick & ~capcmp_b_select & eq_b;
  wire os_fire = oneshot_mode & oneshot_trigger & running;

  // ****************************************************************
  // counter next value
  // ****************************************************************
  always @* begin
    if (!running) begin
      count_next = `TMR_CNT_ZERO;
    end else if (os_fire) begin
      count_next = `TMR_CNT_ZERO;
    end else if (edge_clr_mode & vedge_a) begin
      count_next = `TMR_CNT_ZERO;
    end else if (cnt_tick) begin
      if (match_clr_mode & eq_a) begin
        // interval of capcmp_a + 1 counts: 2 .. 65536
        count_next = `TMR_CNT_ZERO;
      end else begin
        count_next = count_reg + `TMR_CNT_ONE;
      end
    end else begin
      count_next = count_reg;
    end
  end

  // ****************************************************************
  // capture triggers
  // ****************************************************************
  wire cap_a_trig = capcmp_a_select & running &
    (capcmp_a_trig_src ? cap_a_from_a : vedge_b);
  // capcmp_b only captures from a pin edge, never from count_rd
  wire cap_b_trig = capcmp_b_select & running & vedge_a;

  // ****************************************************************
  // wave output
  // ****************************************************************
  always @* begin
    wave_next = wave_out;
    oneshot_act_next = oneshot_act_reg;
    if (!wave_enable || !running) begin
      wave_next = 1'b0;
      oneshot_act_next = 1'b0;
    end else if (oneshot_mode) begin
      // pulse rises at capcmp_b and falls at capcmp_a
      if (os_fire) begin
        wave_next = 1'b0;
        oneshot_act_next = 1'b1;
      end else if (oneshot_act_reg & match_a) begin
        wave_next = 1'b0;
        oneshot_act_next = 1'b0;
      end else if (oneshot_act_reg & match_b) begin
        wave_next = 1'b1;
      end
    end else begin
      // square wave: toggle_on_a in match-clear mode
      // PPG: toggle on both, capcmp_a period, capcmp_b width
      if ((toggle_on_a & match_a) ^ (toggle_on_b & match_b)) begin
        wave_next = ~wave_out;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!resetn) begin
      count_reg <= `TMR_CNT_ZERO;
      pre_cnt_reg <= `PRE_ZERO;
      a_prev_reg <= 1'b0;
      b_prev_reg <= 1'b0;
      pend_reg <= 1'b0;
      oneshot_act_reg <= 1'b0;
      count_rd_data <= `TMR_CNT_ZERO;
      capcmp_a <= `TMR_CNT_ZERO;
      capcmp_b <= `TMR_CNT_ZERO;
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
      overflow <= 1'b0;
      wave_out <= 1'b0;
    end else if (clk_en) begin
      count_reg <= count_next;
      pend_reg <= pend_next;
      oneshot_act_reg <= oneshot_act_next;
      wave_out <= wave_next;
      match_a_irq <= match_a;
      match_b_irq <= match_b;
      if (fxp_tick) begin
        pre_cnt_reg <= pre_cnt_reg + `PRE_ONE;
        a_prev_reg <= edge_in_a;
        b_prev_reg <= edge_in_b;
      end
      if (count_rd) begin
        count_rd_data <= count_reg;
      end
      // capture wins over a write in the same cycle
      if (cap_a_trig) begin
        capcmp_a <= count_reg;
      end else if (capcmp_a_wr) begin
        capcmp_a <= wr_data;
      end
      if (cap_b_trig) begin
        capcmp_b <= count_reg;
      end else if (capcmp_b_wr) begin
        capcmp_b <= wr_data;
      end
      // set wins over clear
      if (cnt_tick & (count_reg == `TMR_CNT_MAX) & ~match_clr_mode) begin
        overflow <= 1'b1;
      end else if (overflow_clr) begin
        overflow <= 1'b0;
      end
    end
  end

endmodule

// file: timer_regs.vh
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// ****************************************************************
// counter geometry and reset values
// ****************************************************************
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_ONE 16'h0001
`define TMR_CNT_MAX 16'hFFFF

// ****************************************************************
// run-mode codes {run_mode_hi, run_mode_lo}
// ****************************************************************
`define TMR_RUN_STOP 2'h0
`define TMR_RUN_FREE 2'h1
`define TMR_RUN_EDGE_CLR 2'h2
`define TMR_RUN_MATCH_CLR 2'h3

// ****************************************************************
// peripheral clock divider codes (periph_clk_div)
// ****************************************************************
`define PCLK_DIV1 2'h0
`define PCLK_DIV2 2'h1
`define PCLK_DIV4 2'h2
`define PCLK_CNT_W 2
`define PCLK_CNT_ZERO 2'h0
`define PCLK_CNT_ONE 2'h1
`define PCLK_MASK_DIV2 2'h1
`define PCLK_MASK_DIV4 2'h3

// ****************************************************************
// count clock source codes (count_src)
// ****************************************************************
`define CSRC_FXP 2'h0
`define CSRC_FXP4 2'h1
`define CSRC_FXP16 2'h2
`define CSRC_EVENT 2'h3
`define PRE_CNT_W 4
`define PRE_ZERO 4'h0
`define PRE_ONE 4'h1
`define PRE_DIV4_MASK 4'h3
`define PRE_DIV16_MASK 4'hF

// ****************************************************************
// edge select codes {edge_sel_hi, edge_sel_lo}
// ****************************************************************
`define ESEL_FALL 2'h0
`define ESEL_RISE 2'h1
`define ESEL_NONE 2'h2
`define ESEL_BOTH 2'h3

`endif
